/* fifo_device_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Behavioural buffer device seen from its processor-side pins
// ----------------------------------------------------------------
module fifo_device_model #(
  parameter logic [7:0] VECTOR = 8'h5a // Arbitrary value
) (
  input wire logic mclk_i,
  input wire host_port_pkg::strobes_s strb_i,
  input wire logic [3:0] reg_select_i,
  input wire logic [7:0] host_bus_i,
  input wire logic host_oe_n_i,
  input wire logic [7:0] wait_len_i,
  input wire logic dma_req_i,
  input wire logic irq_set_i,
  input wire logic prio_chain_in_i,
  output logic prio_chain_out_o,
  output logic [7:0] bus_o,
  output logic req_wait_n_o,
  output logic irq_n_o
);
  logic [7:0] regs [16];
  logic [7:0] fifo_q = 8'h00;
  logic [7:0] ctrl_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic [7:0] drv;
  logic [7:0] wait_cnt = 8'h00;
  logic [3:0] addr_q = 4'h0;
  logic cs_q = 1'b1;
  logic ack_q = 1'b1;
  logic pend_q = 1'b0;
  logic as_q = 1'b1;
  logic addr_bad = 1'b0;
  logic den;
  logic nm_sel;

  assign nm_sel = !strb_i.chip_en_n || !strb_i.dma_grant_n;

  always_comb begin
    den = 1'b1;
    drv = 8'h00;
    if (!strb_i.data_strobe_n && strb_i.rw && !ack_q) begin
      drv = VECTOR;
    end else if (!strb_i.data_strobe_n && strb_i.rw && !cs_q) begin
      drv = regs[addr_q];
    end else if (!strb_i.dma_strobe_n && strb_i.rw) begin
      drv = fifo_q;
    end else if (!strb_i.rd_n && nm_sel) begin
      drv = (!strb_i.dma_grant_n || !strb_i.ctrl_data) ? fifo_q :
        ctrl_q;
    end else begin
      den = 1'b0;
    end
  end

  // Released lines flip each cycle between the last byte and its inverse
  assign bus_o = !host_oe_n_i ? host_bus_i : (den ? drv : ~last_q);
  assign req_wait_n_o = !((wait_cnt != 8'h00) || dma_req_i);
  assign irq_n_o = !pend_q;
  // Service is taken to end with the acknowledge cycle itself
  assign prio_chain_out_o = prio_chain_in_i && !pend_q &&
    (ack_q || strb_i.irq_ack_n);

  always @(posedge strb_i.addr_strobe_n) begin
    cs_q <= strb_i.cs_n;
    ack_q <= strb_i.irq_ack_n;
  end

  always @(posedge mclk_i) begin
    last_q <= bus_o;
    as_q <= strb_i.addr_strobe_n;
    if (!strb_i.addr_strobe_n) begin
      addr_q <= reg_select_i;
      if (bus_o[3:0] !== reg_select_i) addr_bad <= 1'b1;
    end
    if (!strb_i.data_strobe_n && !strb_i.rw && !cs_q) regs[addr_q] <= bus_o;
    if (!strb_i.dma_strobe_n && !strb_i.rw) fifo_q <= bus_o;
    if (!strb_i.wr_n && nm_sel) begin
      if (strb_i.ctrl_data && strb_i.dma_grant_n) ctrl_q <= bus_o;
      else fifo_q <= bus_o;
    end
    if (irq_set_i) pend_q <= 1'b1;
    else if (!ack_q && !strb_i.data_strobe_n) pend_q <= 1'b0;
    // Wait is pulled early since the host syncs it over several cycles
    if (as_q && !strb_i.addr_strobe_n) wait_cnt <= wait_len_i;
    else if (wait_cnt != 8'h00) wait_cnt <= wait_cnt - 8'h01;
  end
endmodule

/* fifo_host_bus_port.sv */
`timescale 1ns/1ps
module fifo_host_bus_port (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire host_port_pkg::cmd_s cmd_i,
  output logic rsp_valid_o,
  output logic [host_port_pkg::BUS_W-1:0] rsp_data_o,
  output logic irq_pending_o,
  output logic dma_request_o,
  output logic [host_port_pkg::BUS_W-1:0] mux_addr_data_bus_o,
  output logic mux_addr_data_bus_oe_n_o,
  input wire logic [host_port_pkg::BUS_W-1:0] mux_addr_data_bus_i,
  output logic [host_port_pkg::SEL_W-1:0] reg_select_o,
  output host_port_pkg::strobes_s strobes_o,
  input wire logic req_wait_n_i,
  input wire logic irq_n_i
);

  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;
  logic req_wait_n_s;
  logic irq_n_s;
  logic [host_port_pkg::BUS_W-1:0] bus_s;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  pin_sync #(.WIDTH(1), .INIT(1'b1)) u_wait_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i(req_wait_n_i),
    .level_o(req_wait_n_s)
  );
  pin_sync #(.WIDTH(1), .INIT(1'b1)) u_irq_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i(irq_n_i),
    .level_o(irq_n_s)
  );
  // Read data reaches the answer four cycles late, so the pins are sampled early in the strobe
  pin_sync #(.WIDTH(host_port_pkg::BUS_W),
    .INIT(host_port_pkg::BUS_IDLE)) u_bus_sync (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .pin_i(mux_addr_data_bus_i),
    .level_o(bus_s)
  );
  // Device requests and interrupts, seen as plain levels
  assign irq_pending_o = !irq_n_s;
  assign dma_request_o = !req_wait_n_s;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  host_port_pkg::state_e state_q;
  host_port_pkg::state_e state_d;
  host_port_pkg::cmd_s cur_q;
  logic tmr_load;
  logic [host_port_pkg::TMR_W-1:0] tmr_count;
  logic tmr_done;
  logic take;
  logic mux;
  logic finish;
  logic stretch;

  assign cmd_ready_o = (state_q == host_port_pkg::ST_IDLE);
  assign take = cmd_valid_i && cmd_ready_o;
  assign mux = cur_q.mux_mode;
  // Wait only stretches CPU cycles; DMA pacing uses the request
  assign stretch = cur_q.use_wait && !req_wait_n_s &&
    (cur_q.kind != host_port_pkg::K_DMA);
  assign finish = ((state_q == host_port_pkg::ST_DATA) && tmr_done &&
    !stretch) || ((state_q == host_port_pkg::ST_WAIT) && req_wait_n_s);

  step_timer u_timer (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .load_i(tmr_load),
    .count_i(tmr_count),
    .done_o(tmr_done)
  );

  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_count = host_port_pkg::DS_CYC;
    case (state_q)
      host_port_pkg::ST_IDLE: begin
        if (take) begin
          tmr_load = 1'b1;
          if (cmd_i.mux_mode && (cmd_i.kind != host_port_pkg::K_DMA)) begin
            state_d = host_port_pkg::ST_ADDR;
            tmr_count = host_port_pkg::AS_CYC;
          end else begin
            state_d = host_port_pkg::ST_DATA;
          end
        end
      end
      host_port_pkg::ST_ADDR: begin
        if (tmr_done) begin
          state_d = host_port_pkg::ST_GAP;
          tmr_load = 1'b1;
          tmr_count = host_port_pkg::GAP_CYC;
        end
      end
      host_port_pkg::ST_GAP: begin
        if (tmr_done) begin
          state_d = host_port_pkg::ST_DATA;
          tmr_load = 1'b1;
        end
      end
      host_port_pkg::ST_DATA: begin
        if (tmr_done) begin
          state_d = stretch ? host_port_pkg::ST_WAIT :
            host_port_pkg::ST_RECOV;
          tmr_load = !stretch;
          tmr_count = host_port_pkg::REC_CYC;
        end
      end
      host_port_pkg::ST_WAIT: begin
        if (req_wait_n_s) begin
          state_d = host_port_pkg::ST_RECOV;
          tmr_load = 1'b1;
          tmr_count = host_port_pkg::REC_CYC;
        end
      end
      host_port_pkg::ST_RECOV: begin
        if (tmr_done) begin
          state_d = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= host_port_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Command is frozen for the whole cycle so pins cannot move
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cur_q <= '0;
    end else if (take) begin
      cur_q <= cmd_i;
      if (cmd_i.kind == host_port_pkg::K_IRQ_ACK_N) begin
        cur_q.write <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shared address/data lines
  // ----------------------------------------------------------------
  logic [host_port_pkg::BUS_W-1:0] bus_q;
  logic bus_oe_n_q;

  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_q <= host_port_pkg::BUS_IDLE;
      bus_oe_n_q <= 1'b1;
    end else if (take) begin
      if (cmd_i.mux_mode && (cmd_i.kind != host_port_pkg::K_DMA)) begin
        bus_q <= {host_port_pkg::ADDR_PAD, cmd_i.addr};
        bus_oe_n_q <= 1'b0;
      end else begin
        bus_q <= cmd_i.data;
        bus_oe_n_q <= !cmd_i.write;
      end
    end else if ((state_q == host_port_pkg::ST_GAP) && tmr_done) begin
      bus_q <= cur_q.data;
      bus_oe_n_q <= !cur_q.write;
    end else if (finish) begin
      bus_oe_n_q <= 1'b1;
    end
  end

  assign mux_addr_data_bus_o = bus_q;
  assign mux_addr_data_bus_oe_n_o = bus_oe_n_q;
  assign reg_select_o = cur_q.addr;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  logic in_addr;
  logic in_data;
  logic busy;

  assign in_addr = (state_q == host_port_pkg::ST_ADDR);
  assign in_data = (state_q == host_port_pkg::ST_DATA) ||
    (state_q == host_port_pkg::ST_WAIT);
  assign busy = in_addr || in_data || (state_q == host_port_pkg::ST_GAP);

  always_comb begin
    strobes_o.addr_strobe_n = !(mux && in_addr);
    strobes_o.data_strobe_n = !(mux && in_data &&
      (cur_q.kind != host_port_pkg::K_DMA));
    strobes_o.dma_strobe_n = !(mux && in_data &&
      (cur_q.kind == host_port_pkg::K_DMA));
    strobes_o.rw = !(busy && cur_q.write);
    // Held past the strobe's rise so the device latches it
    strobes_o.cs_n = !(mux && busy &&
      (cur_q.kind == host_port_pkg::K_REG));
    strobes_o.irq_ack_n = !(busy &&
      (cur_q.kind == host_port_pkg::K_IRQ_ACK_N));
    strobes_o.rd_n = !(!mux && in_data && !cur_q.write);
    strobes_o.wr_n = !(!mux && in_data && cur_q.write);
    strobes_o.chip_en_n = !(!mux && in_data &&
      (cur_q.kind == host_port_pkg::K_REG));
    strobes_o.dma_grant_n = !(!mux && in_data &&
      (cur_q.kind == host_port_pkg::K_DMA));
    strobes_o.ctrl_data = cur_q.ctrl_byte;
  end

  // ----------------------------------------------------------------
  // Answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= host_port_pkg::BUS_IDLE;
    end else begin
      rsp_valid_o <= finish;
      if (finish && !cur_q.write) begin
        rsp_data_o <= bus_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_addr_hold;
    @(posedge mclk_i) disable iff (!rst_n)
    !strobes_o.addr_strobe_n && $past(!strobes_o.addr_strobe_n) |->
      $stable(reg_select_o) && $stable(strobes_o.cs_n) &&
      $stable(strobes_o.irq_ack_n) && $stable(mux_addr_data_bus_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address group moved while address strobe low");
  property p_addr_first;
    @(posedge mclk_i) disable iff (!rst_n)
    $rose(strobes_o.addr_strobe_n) |->
      ##2 !strobes_o.data_strobe_n && mux_addr_data_bus_o == cur_q.data;
  endproperty
  a_addr_first: assert property (p_addr_first)
    else $error("data phase did not follow address phase");
  property p_cs_latched;
    @(posedge mclk_i) disable iff (!rst_n)
    $rose(strobes_o.addr_strobe_n) && cur_q.kind == host_port_pkg::K_REG
      |-> $past(!strobes_o.cs_n) && !strobes_o.cs_n;
  endproperty
  a_cs_latched: assert property (p_cs_latched)
    else $error("chip select not valid at address strobe rise");
  property p_rw_dir;
    @(posedge mclk_i) disable iff (!rst_n)
    !strobes_o.data_strobe_n |-> strobes_o.rw == !cur_q.write;
  endproperty
  a_rw_dir: assert property (p_rw_dir)
    else $error("direction line wrong during data strobe");
  property p_ds_width;
    @(posedge mclk_i) disable iff (!rst_n)
    $fell(strobes_o.data_strobe_n) |-> !strobes_o.data_strobe_n[*5];
  endproperty
  a_ds_width: assert property (p_ds_width)
    else $error("data strobe shorter than its least width");
  property p_dma_pulse;
    @(posedge mclk_i) disable iff (!rst_n)
    $fell(strobes_o.dma_strobe_n) |->
      !strobes_o.dma_strobe_n[*5] ##1 strobes_o.dma_strobe_n;
  endproperty
  a_dma_pulse: assert property (p_dma_pulse)
    else $error("DMA strobe pulse has wrong width");
  property p_grant;
    @(posedge mclk_i) disable iff (!rst_n)
    !strobes_o.dma_grant_n |->
      (strobes_o.rd_n != strobes_o.wr_n) && strobes_o.chip_en_n;
  endproperty
  a_grant: assert property (p_grant)
    else $error("DMA grant without a single strobe");
  property p_rd_wr;
    @(posedge mclk_i) disable iff (!rst_n)
    !strobes_o.wr_n |-> strobes_o.rd_n && cur_q.write &&
      !mux_addr_data_bus_oe_n_o;
  endproperty
  a_rd_wr: assert property (p_rd_wr)
    else $error("write strobe with read strobe or bus released");
  property p_chip_en;
    @(posedge mclk_i) disable iff (!rst_n)
    (!strobes_o.rd_n || !strobes_o.wr_n) &&
      cur_q.kind == host_port_pkg::K_REG |->
      !strobes_o.chip_en_n && strobes_o.ctrl_data == cur_q.ctrl_byte;
  endproperty
  a_chip_en: assert property (p_chip_en)
    else $error("CPU strobe without chip enable or byte type");
  property p_ack;
    @(posedge mclk_i) disable iff (!rst_n)
    !strobes_o.irq_ack_n |-> cur_q.kind == host_port_pkg::K_IRQ_ACK_N &&
      strobes_o.rw && strobes_o.cs_n;
  endproperty
  a_ack: assert property (p_ack)
    else $error("interrupt acknowledge outside an acknowledge cycle");
endmodule

/* fifo_host_bus_port_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  n_fail++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module fifo_host_bus_port_bench;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  logic cmd_ready_o, rsp_valid_o, irq_pending_o, dma_request_o;
  logic bus_oe_n, req_wait_n, irq_n, chain_in = 1'b1, chain_out;
  logic dma_req = 1'b0;
  logic irq_set = 1'b0;
  logic [7:0] wait_len = 8'h00;
  logic [7:0] rsp_data_o, bus_out, bus_in, rd;
  logic [3:0] reg_select_o;
  host_port_pkg::cmd_s cmd_i = '0;
  host_port_pkg::strobes_s strobes_o;
  int n_fail = 0;
  int num_checks = 0;
  int cyc;
  localparam int MUX_CYC = host_port_pkg::AS_CYC + host_port_pkg::GAP_CYC +
    host_port_pkg::DS_CYC;
  localparam int DATA_CYC = host_port_pkg::DS_CYC;

  fifo_host_bus_port dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
    .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
    .irq_pending_o(irq_pending_o), .dma_request_o(dma_request_o),
    .mux_addr_data_bus_o(bus_out), .mux_addr_data_bus_oe_n_o(bus_oe_n),
    .mux_addr_data_bus_i(bus_in), .reg_select_o(reg_select_o),
    .strobes_o(strobes_o), .req_wait_n_i(req_wait_n), .irq_n_i(irq_n));
  fifo_device_model dev_u (.mclk_i(mclk_i), .strb_i(strobes_o),
    .reg_select_i(reg_select_o), .host_bus_i(bus_out),
    .host_oe_n_i(bus_oe_n), .wait_len_i(wait_len), .dma_req_i(dma_req),
    .irq_set_i(irq_set), .prio_chain_in_i(chain_in),
    .prio_chain_out_o(chain_out), .bus_o(bus_in),
    .req_wait_n_o(req_wait_n), .irq_n_o(irq_n));

  initial begin
    forever #20 mclk_i = ~mclk_i;
  end

  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // One command, entered and left at a falling edge
  // ----------------------------------------------------------------
  task automatic acc(input logic mux, input host_port_pkg::kind_e k,
    input logic wr, input logic [3:0] a, input logic [7:0] d,
    input logic cd, input logic uw);
    int n;
    n = 0;
    cmd_i = '{mux, k, wr, a, d, cd, uw};
    cmd_valid_i = 1'b1;
    while (cmd_ready_o !== 1'b1 && n < 50) begin
      @(negedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    cmd_valid_i = 1'b0;
    cyc = 0;
    while (rsp_valid_o !== 1'b1 && cyc < 100) begin
      @(negedge mclk_i);
      cyc++;
    end
    if (cyc >= 100 || n >= 50) n_fail++;
    rd = rsp_data_o;
  endtask

  task automatic t_mux_reg();
    for (int i = 0; i < 16; i++) begin
      acc(1'b1, host_port_pkg::K_REG, 1'b1, i[3:0], 8'h3c ^ i[7:0], 0, 0);
      `CHK("mux wr cycles", MUX_CYC, cyc)
      `CHK("dev reg", 8'h3c ^ i[7:0], dev_u.regs[i])
    end
    for (int i = 15; i >= 0; i--) begin
      acc(1'b1, host_port_pkg::K_REG, 1'b0, i[3:0], 8'h00, 0, 0);
      `CHK("mux rd data", 8'h3c ^ i[7:0], rd)
    end
    `CHK("addr phase", 1'b0, dev_u.addr_bad)
  endtask

  task automatic t_mux_dma();
    acc(1'b1, host_port_pkg::K_DMA, 1'b1, 4'h0, 8'ha5, 0, 0);
    `CHK("dma wr", 8'ha5, dev_u.fifo_q)
    `CHK("dma cycles", DATA_CYC, cyc)
    acc(1'b1, host_port_pkg::K_DMA, 1'b0, 4'h0, 8'h00, 0, 0);
    `CHK("dma rd", 8'ha5, rd)
  endtask

  task automatic t_nonmux();
    acc(1'b0, host_port_pkg::K_REG, 1'b1, 4'h0, 8'h81, 1, 0);
    `CHK("nm wr cycles", DATA_CYC, cyc)
    acc(1'b0, host_port_pkg::K_REG, 1'b1, 4'h0, 8'h42, 0, 0);
    acc(1'b0, host_port_pkg::K_REG, 1'b0, 4'h0, 8'h00, 1, 0);
    `CHK("nm ctrl rd", 8'h81, rd)
    acc(1'b0, host_port_pkg::K_REG, 1'b0, 4'h0, 8'h00, 0, 0);
    `CHK("nm data rd", 8'h42, rd)
    acc(1'b0, host_port_pkg::K_DMA, 1'b1, 4'h0, 8'h99, 1, 0);
    `CHK("nm dma wr", 8'h99, dev_u.fifo_q)
    acc(1'b0, host_port_pkg::K_DMA, 1'b0, 4'h0, 8'h00, 0, 0);
    `CHK("nm dma rd", 8'h99, rd)
    `CHK("nm ctrl kept", 8'h81, dev_u.ctrl_q)
  endtask

  task automatic t_wait();
    wait_len = 8'h0a;
    acc(1'b1, host_port_pkg::K_REG, 1'b0, 4'h3, 8'h00, 0, 1);
    `CHK("stretched", 1'b1, cyc > MUX_CYC)
    `CHK("wait rd", 8'h3f, rd)
    acc(1'b1, host_port_pkg::K_REG, 1'b0, 4'h3, 8'h00, 0, 0);
    `CHK("wait ignored", MUX_CYC, cyc)
    wait_len = 8'h00;
    repeat (8) @(negedge mclk_i);
    `CHK("dma request idle", 1'b0, dma_request_o)
    dma_req = 1'b1;
    repeat (6) @(negedge mclk_i);
    `CHK("dma request", 1'b1, dma_request_o)
    dma_req = 1'b0;
    repeat (6) @(negedge mclk_i);
    `CHK("dma request off", 1'b0, dma_request_o)
  endtask

  task automatic t_irq();
    irq_set = 1'b1;
    @(negedge mclk_i);
    irq_set = 1'b0;
    repeat (6) @(negedge mclk_i);
    `CHK("irq pending", 1'b1, irq_pending_o)
    `CHK("chain blocked", 1'b0, chain_out)
    acc(1'b1, host_port_pkg::K_IRQ_ACK_N, 1'b0, 4'h0, 8'h00, 0, 0);
    `CHK("vector", 8'h5a, rd)
    repeat (6) @(negedge mclk_i);
    `CHK("irq cleared", 1'b0, irq_pending_o)
    `CHK("chain open", 1'b1, chain_out)
    chain_in = 1'b0;
    @(negedge mclk_i);
    `CHK("chain from above", 1'b0, chain_out)
    chain_in = 1'b1;
  endtask

  initial begin
    repeat (20) @(negedge mclk_i);
    `CHK("idle as", 1'b1, strobes_o.addr_strobe_n)
    `CHK("idle ds", 1'b1, strobes_o.data_strobe_n)
    `CHK("idle oe", 1'b1, bus_oe_n)
    rst_n_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    t_mux_reg();
    t_mux_dma();
    t_nonmux();
    t_wait();
    t_irq();
    end_of_test();
  end

  // Whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk_i);
    n_fail++;
    end_of_test();
  end
endmodule

/* host_port_pkg.sv */
package host_port_pkg;

  // ----------------------------------------------------------------
  // Timing, in ns as quoted, and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int AS_NS = 80;
  localparam int GAP_NS = 40;
  localparam int DS_NS = 200;
  localparam int REC_NS = 80;
  localparam int TMR_W = 4;

  // Least times: round up to whole cycles
  localparam logic [TMR_W-1:0] AS_CYC = TMR_W'((AS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] GAP_CYC =
    TMR_W'((GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] DS_CYC = TMR_W'((DS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [TMR_W-1:0] REC_CYC =
    TMR_W'((REC_NS + CLK_NS - 1) / CLK_NS);

  // ----------------------------------------------------------------
  // Widths and fixed values
  // ----------------------------------------------------------------
  localparam int BUS_W = 8;
  localparam int SEL_W = 4;
  localparam int SYNC_STAGES = 3;
  localparam logic [BUS_W-SEL_W-1:0] ADDR_PAD = 4'h0;
  localparam logic [BUS_W-1:0] BUS_IDLE = 8'h00;

  // ----------------------------------------------------------------
  // Enumerations and carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    K_REG = 2'h0,
    K_DMA = 2'h1,
    K_IRQ_ACK_N = 2'h2
  } kind_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_GAP = 3'h2,
    ST_DATA = 3'h3,
    ST_WAIT = 3'h4,
    ST_RECOV = 3'h5
  } state_e;

  typedef struct packed {
    logic mux_mode;
    kind_e kind;
    logic write;
    logic [SEL_W-1:0] addr;
    logic [BUS_W-1:0] data;
    logic ctrl_byte;
    logic use_wait;
  } cmd_s;

  typedef struct packed {
    logic addr_strobe_n;
    logic data_strobe_n;
    logic dma_strobe_n;
    logic rw;
    logic cs_n;
    logic irq_ack_n;
    logic rd_n;
    logic wr_n;
    logic chip_en_n;
    logic dma_grant_n;
    logic ctrl_data;
  } strobes_s;

endpackage

/* pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pin_i,
  output logic [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Bit moves only once stages two and three agree
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_o <= INIT;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          level_o[i] <= s3_q[i];
        end
      end
    end
  end
endmodule

/* step_timer.sv */
`timescale 1ns/1ps
module step_timer (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic load_i,
  input wire logic [host_port_pkg::TMR_W-1:0] count_i,
  output logic done_o
);
  logic [host_port_pkg::TMR_W-1:0] cnt_q;

  // Loading N keeps the following state for exactly N cycles
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= '0;
    end else if (load_i) begin
      cnt_q <= count_i - host_port_pkg::TMR_W'(1);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - host_port_pkg::TMR_W'(1);
    end
  end

  assign done_o = (cnt_q == '0);
endmodule
